// ---- hw/trsw_writer.v ----
/*
 * Trace record store writer: captures branch and precise sampling events,
 * fetches buffer pointers from the management area and writes records out
 * over a simple memory master port; registers over classic wishbone.
 * Assumes processor-side inputs are on clk_i and that memory answers every
 * request with a one-cycle mem_ack_i.
 */
`timescale 1ns/1ps
`include "trsw_defines.vh"

// Overview of operation
// - with branch enable set, a taken branch, interrupt or exception stores a record unless an earlier one is still pending
// - sampling overflow stores flags, linear pointer and eight general registers
// - after logging a sample the counter is reloaded and counting resumes
// - entering system management mode clears and suppresses all recording
// - machine check, reset and soft init clear the recording enables
// - real address mode changes nothing; recording keeps working
// - misc_feature_enable shows branch_trace_absent and sampling_absent read-only flags
// - feature_query bit 21 shows the trace store mechanism is present
// - store_area_pointer gives the management area; all pointers fetched from it
// - branch record of 12 bytes written at branch index, index then advanced
// - branch absolute maximum is first byte past branch buffer
// - writing the branch record at the threshold address raises an interrupt pulse
// - sampling record of 40 bytes written at sampling index, index then advanced
// - sampling absolute maximum is first byte past sampling buffer
// - writing the sampling record at the threshold address raises an interrupt pulse
// - a 40-bit reload value from the management area reloads the counter
// - branch record holds linear source and linear target addresses
// - bit 4 of the third branch word shows the branch was predicted
// - sampled registers are those presented at the overflowing event
// - stored instruction pointer is code segment base plus offset
// - sample layout: flags, pointer, then accumulator through stack pointer in 4-byte slots
// - only the fifth queue group counter produces sampling records
module trsw_writer #(
    parameter BR_ABSENT = 1'b0,
    parameter SP_ABSENT = 1'b0
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire branch_evt_i,
    input wire [31:0] branch_from_i,
    input wire [31:0] branch_to_i,
    input wire branch_pred_i,
    input wire count_evt_i,
    input wire [31:0] flags_register_i,
    input wire [31:0] instruction_pointer_i,
    input wire [31:0] code_base_i,
    input wire [255:0] gpr_i,
    input wire system_management_mode_i,
    input wire machine_check_i,
    input wire soft_init_i,
    input wire real_mode_i,
    output reg mem_req_o,
    output reg mem_we_o,
    output reg [31:0] mem_addr_o,
    output reg [31:0] mem_wdata_o,
    input wire mem_ack_i,
    input wire [31:0] mem_rdata_i,
    output reg branch_irq_o,
    output reg sampling_irq_o
);

    localparam S_IDLE = 3'd0;
    localparam S_RD = 3'd1;
    localparam S_CHK = 3'd2;
    localparam S_WR = 3'd3;
    localparam S_UPD = 3'd4;

    reg [2:0] state;
    reg kind;
    reg [3:0] step;
    reg [31:0] ctrl;
    reg [31:0] area;
    reg [39:0] counter;
    reg [4:0] stat;
    reg br_pend, sp_pend;
    reg [31:0] br_from, br_to;
    reg br_pred;
    reg [31:0] snap [0:9];
    reg [31:0] f_idx, f_max, f_thr, f_rlo;
    reg [7:0] f_rhi;
    reg br_done, sp_done, do_reload, br_full_set, sp_full_set;
    reg [31:0] rd_mux;
    integer n;

    wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_hit & wb_we_i;
    // recording is off as long as the processor sits in system management mode
    wire rec_ok = ~system_management_mode_i;
    wire br_fire = branch_evt_i & ctrl[`TRSW_CTRL_BR_EN] & rec_ok & ~BR_ABSENT;
    // counter holds while a sample is waiting, so a second overflow cannot be lost
    wire cnt_inc = count_evt_i & ~sp_pend;
    wire cnt_ovf = cnt_inc & (&counter);
    wire sp_fire = cnt_ovf & ctrl[`TRSW_CTRL_SP_EN] & rec_ok & ~SP_ABSENT;
    wire [31:0] kbase = kind ? `TRSW_MA_SP_BASE : `TRSW_MA_BR_BASE;
    wire [31:0] rsize = kind ? `TRSW_SP_SIZE : `TRSW_BR_SIZE;
    wire [3:0] nreads = kind ? `TRSW_SP_READS : `TRSW_BR_READS;
    wire [3:0] nwords = kind ? `TRSW_SP_WORDS : `TRSW_BR_WORDS;
    wire [31:0] next_idx = f_idx + rsize;

    function [31:0] wmask;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] sel;
        integer b;
        begin
            wmask = old_v;
            for (b = 0; b < 4; b = b + 1) begin
                if (sel[b]) begin
                    wmask[8*b +: 8] = new_v[8*b +: 8];
                end
            end
        end
    endfunction

    // record word w of the current kind; sampling slots follow the fixed layout
    function [31:0] rec_word;
        input k;
        input [3:0] w;
        begin
            if (k) begin
                rec_word = snap[w];
            end else begin
                case (w)
                    4'h0: rec_word = br_from;
                    4'h1: rec_word = br_to;
                    4'h2: rec_word = {27'h0000000, br_pred, 4'h0};
                    default: rec_word = 32'h00000000;
                endcase
            end
        end
    endfunction

    // enables, pointer and status; hardware set beats a software clear
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `TRSW_CTRL_RST;
            area <= 32'h00000000;
            stat <= 5'h00;
        end else begin
            if (wb_wr && wb_adr_i == `TRSW_REG_CTRL) begin
                ctrl <= wmask(ctrl, wb_dat_i, wb_sel_i) & 32'h00000003;
            end
            if (system_management_mode_i || machine_check_i || soft_init_i) begin
                ctrl <= `TRSW_CTRL_RST;
            end
            if (wb_wr && wb_adr_i == `TRSW_REG_AREA) begin
                area <= wmask(area, wb_dat_i, wb_sel_i);
            end
            if (wb_wr && wb_adr_i == `TRSW_REG_STAT && wb_sel_i[0]) begin
                stat <= stat & ~wb_dat_i[4:0];
            end
            if (br_full_set) begin
                stat[`TRSW_STAT_BR_FULL] <= 1'b1;
            end
            if (sp_full_set) begin
                stat[`TRSW_STAT_SP_FULL] <= 1'b1;
            end
            if (br_fire && br_pend && !br_done) begin
                stat[`TRSW_STAT_BR_DROP] <= 1'b1;
            end
        end
    end

    // event capture; a new branch in the done cycle is kept
    always @(posedge clk_i) begin
        if (rst_i) begin
            br_pend <= 1'b0;
            sp_pend <= 1'b0;
            br_from <= 32'h00000000;
            br_to <= 32'h00000000;
            br_pred <= 1'b0;
            for (n = 0; n < 10; n = n + 1) begin
                snap[n] <= 32'h00000000;
            end
        end else begin
            if (br_done) begin
                br_pend <= 1'b0;
            end
            if (sp_done) begin
                sp_pend <= 1'b0;
            end
            if (br_fire && (!br_pend || br_done)) begin
                br_pend <= 1'b1;
                br_from <= branch_from_i;
                br_to <= branch_to_i;
                br_pred <= branch_pred_i;
            end
            if (sp_fire) begin
                sp_pend <= 1'b1;
                snap[0] <= flags_register_i;
                snap[1] <= code_base_i + instruction_pointer_i;
                for (n = 0; n < 8; n = n + 1) begin
                    snap[n + 2] <= gpr_i[32*n +: 32];
                end
            end
        end
    end

    // fifth queue group counter
    always @(posedge clk_i) begin
        if (rst_i) begin
            counter <= 40'h0000000000;
        end else if (do_reload) begin
            counter <= {f_rhi, f_rlo};
        end else if (wb_wr && wb_adr_i == `TRSW_REG_CLO) begin
            counter[31:0] <= wmask(counter[31:0], wb_dat_i, wb_sel_i);
        end else if (wb_wr && wb_adr_i == `TRSW_REG_CHI && wb_sel_i[0]) begin
            counter[39:32] <= wb_dat_i[7:0];
        end else if (cnt_inc) begin
            counter <= counter + 40'h0000000001;
        end
    end

    // record writer; one request stays up until acked, next may follow at once
    always @(posedge clk_i) begin
        if (rst_i) begin
            state <= S_IDLE;
            kind <= 1'b0;
            step <= 4'h0;
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_addr_o <= 32'h00000000;
            mem_wdata_o <= 32'h00000000;
            f_idx <= 32'h00000000;
            f_max <= 32'h00000000;
            f_thr <= 32'h00000000;
            f_rlo <= 32'h00000000;
            f_rhi <= 8'h00;
            br_done <= 1'b0;
            sp_done <= 1'b0;
            do_reload <= 1'b0;
            br_full_set <= 1'b0;
            sp_full_set <= 1'b0;
            branch_irq_o <= 1'b0;
            sampling_irq_o <= 1'b0;
        end else begin
            br_done <= 1'b0;
            sp_done <= 1'b0;
            do_reload <= 1'b0;
            br_full_set <= 1'b0;
            sp_full_set <= 1'b0;
            branch_irq_o <= 1'b0;
            sampling_irq_o <= 1'b0;
            case (state)
                S_IDLE: begin
                    // pointers are fetched fresh per record, software may move them
                    if ((sp_pend && !sp_done) || (br_pend && !br_done)) begin
                        kind <= sp_pend && !sp_done;
                        step <= 4'h0;
                        mem_req_o <= 1'b1;
                        mem_we_o <= 1'b0;
                        mem_addr_o <= area + ((sp_pend && !sp_done) ? `TRSW_MA_SP_BASE : `TRSW_MA_BR_BASE)
                            + `TRSW_MA_IDX;
                        state <= S_RD;
                    end
                end
                S_RD: begin
                    if (mem_ack_i) begin
                        case (step)
                            4'h0: f_idx <= mem_rdata_i;
                            4'h1: f_max <= mem_rdata_i;
                            4'h2: f_thr <= mem_rdata_i;
                            4'h3: f_rlo <= mem_rdata_i;
                            default: f_rhi <= mem_rdata_i[7:0];
                        endcase
                        if (step == nreads - 4'h1) begin
                            mem_req_o <= 1'b0;
                            state <= S_CHK;
                        end else begin
                            step <= step + 4'h1;
                            mem_addr_o <= mem_addr_o + 32'h00000004;
                        end
                    end
                end
                S_CHK: begin
                    step <= 4'h0;
                    // maximum is one past the last byte; a record must end before it
                    if (next_idx < f_max) begin
                        mem_req_o <= 1'b1;
                        mem_we_o <= 1'b1;
                        mem_addr_o <= f_idx;
                        mem_wdata_o <= rec_word(kind, 4'h0);
                        state <= S_WR;
                    end else begin
                        br_full_set <= ~kind;
                        sp_full_set <= kind;
                        br_done <= ~kind;
                        sp_done <= kind;
                        do_reload <= kind;
                        state <= S_IDLE;
                    end
                end
                S_WR: begin
                    if (mem_ack_i) begin
                        if (step == nwords - 4'h1) begin
                            mem_addr_o <= area + kbase + `TRSW_MA_IDX;
                            mem_wdata_o <= next_idx;
                            state <= S_UPD;
                        end else begin
                            step <= step + 4'h1;
                            mem_addr_o <= mem_addr_o + 32'h00000004;
                            mem_wdata_o <= rec_word(kind, step + 4'h1);
                        end
                    end
                end
                S_UPD: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        mem_we_o <= 1'b0;
                        branch_irq_o <= ~kind & (f_idx == f_thr);
                        sampling_irq_o <= kind & (f_idx == f_thr);
                        br_done <= ~kind;
                        sp_done <= kind;
                        do_reload <= kind;
                        state <= S_IDLE;
                    end
                end
                default: begin
                    mem_req_o <= 1'b0;
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // real_mode_i is deliberately unused; addressing is linear throughout
    always @* begin
        case (wb_adr_i)
            `TRSW_REG_CTRL: rd_mux = ctrl;
            `TRSW_REG_AREA: rd_mux = area;
            `TRSW_REG_MISC: begin
                rd_mux = 32'h00000000;
                rd_mux[`TRSW_MISC_BR_ABSENT] = BR_ABSENT;
                rd_mux[`TRSW_MISC_SP_ABSENT] = SP_ABSENT;
            end
            `TRSW_REG_FEAT: begin
                rd_mux = 32'h00000000;
                rd_mux[`TRSW_FEAT_STORE] = 1'b1;
            end
            `TRSW_REG_STAT: rd_mux = {27'h0000000, stat[4:1], state != S_IDLE};
            `TRSW_REG_CLO: rd_mux = counter[31:0];
            `TRSW_REG_CHI: rd_mux = {24'h000000, counter[39:32]};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // wishbone slave: one wait state, every address answered
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= wb_hit ? rd_mux : 32'h00000000;
        end
    end

endmodule

// ---- common/trsw_defines.vh ----
/*
 * Constants of the trace record store writer: register offsets, field
 * positions, reset values, management-area layout and record sizes.
 * Assumes it is included by its bare name from the design file.
 */
`ifndef TRSW_DEFINES_VH
`define TRSW_DEFINES_VH

// wishbone register byte offsets
`define TRSW_REG_CTRL 8'h00
`define TRSW_REG_AREA 8'h04
`define TRSW_REG_MISC 8'h08
`define TRSW_REG_FEAT 8'h0C
`define TRSW_REG_STAT 8'h10
`define TRSW_REG_CLO 8'h14
`define TRSW_REG_CHI 8'h18

// debug_control_reg fields
`define TRSW_CTRL_BR_EN 0
`define TRSW_CTRL_SP_EN 1
`define TRSW_CTRL_RST 32'h00000000

// misc_feature_enable read-only fields
`define TRSW_MISC_BR_ABSENT 11
`define TRSW_MISC_SP_ABSENT 12

// feature_query result
`define TRSW_FEAT_STORE 21

// status fields
`define TRSW_STAT_BUSY 0
`define TRSW_STAT_BR_FULL 1
`define TRSW_STAT_SP_FULL 2
`define TRSW_STAT_BR_DROP 3
`define TRSW_STAT_SP_DROP 4

// management area byte offsets; each kind has base, index, max, threshold
`define TRSW_MA_BR_BASE 32'h00000000
`define TRSW_MA_SP_BASE 32'h00000010
`define TRSW_MA_IDX 32'h00000004
`define TRSW_MA_RELOAD 32'h00000020

// record sizes in bytes and in words
`define TRSW_BR_SIZE 32'h0000000C
`define TRSW_SP_SIZE 32'h00000028
`define TRSW_BR_WORDS 4'h3
`define TRSW_SP_WORDS 4'hA
`define TRSW_BR_READS 4'h3
`define TRSW_SP_READS 4'h5

// predicted bit inside the third branch record word
`define TRSW_BR_PRED_BIT 4

`endif

// ---- testbench/trsw_mem_model.sv ----
/*
 * Word memory standing behind the store writer's memory port.
 * Assumes one requester on clk_i that holds req until it sees ack.
 */
`timescale 1ns/1ps
module trsw_mem_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic slow_i,
    output logic ack_o,
    output logic [31:0] rdata_o
);
    logic [31:0] m [0:255];
    logic gap;
    wire go = req_i & ~ack_o & (~slow_i | gap);
    // slow mode inserts one wait cycle per word
    always @(posedge clk_i) begin
        gap <= slow_i & ~gap & req_i & ~ack_o & ~rst_i;
        ack_o <= go & ~rst_i;
        // read data is only meaningful with ack
        rdata_o <= ~rdata_o;
        if (go && !rst_i) begin
            rdata_o <= m[addr_i[9:2]];
            if (we_i)
                m[addr_i[9:2]] <= wdata_i;
        end
    end
endmodule

// ---- testbench/trsw_writer_checker.sv ----
/*
 * Port assertions of the store writer.
 * Assumes the bind at the foot attaches it to every trsw_writer.
 */
`timescale 1ns/1ps
`include "trsw_defines.vh"
module trsw_writer_checker #(
    parameter BR_ABSENT = 1'b0,
    parameter SP_ABSENT = 1'b0
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire mem_req_o,
    input wire mem_we_o,
    input wire [31:0] mem_addr_o,
    input wire [31:0] mem_wdata_o,
    input wire mem_ack_i,
    input wire branch_irq_o,
    input wire sampling_irq_o
);
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire rd = req & ~wb_we_i;
    a_ack_next: assert property (req |=> wb_ack_o) else $error("ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
    a_feat_flag: assert property (rd && wb_adr_i == `TRSW_REG_FEAT |=> wb_dat_o[21])
        else $error("feature bit clear");
    a_absent_flags: assert property (rd && wb_adr_i == `TRSW_REG_MISC |=>
        wb_dat_o[12] == SP_ABSENT && wb_dat_o[11] == BR_ABSENT) else $error("absent flags wrong");
    a_mem_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
        && $stable(mem_wdata_o) && $stable(mem_we_o)) else $error("memory request changed");
    a_birq_after: assert property ($rose(branch_irq_o) |-> ($past(mem_ack_i) && $past(mem_we_o))
        ##1 !branch_irq_o) else $error("branch irq misplaced");
    a_sirq_after: assert property ($rose(sampling_irq_o) |-> ($past(mem_ack_i) && $past(mem_we_o))
        ##1 !sampling_irq_o) else $error("sampling irq misplaced");
    c_birq: cover property (branch_irq_o);
    c_sirq: cover property (sampling_irq_o);
    c_wait: cover property (mem_req_o && mem_we_o && !mem_ack_i ##1 mem_ack_i);
endmodule
bind trsw_writer trsw_writer_checker #(.BR_ABSENT(BR_ABSENT), .SP_ABSENT(SP_ABSENT)) u_chk (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .mem_req_o,
    .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_ack_i, .branch_irq_o, .sampling_irq_o);

// ---- testbench/testbench.sv ----
/*
 * Self-checking bench of trsw_writer with a memory model.
 * Assumes a 200 MHz clock and the register map in trsw_defines.vh.
 */
`timescale 1ns/1ps
`include "trsw_defines.vh"
module testbench;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h0;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, branch_from_i = 32'h0, branch_to_i = 32'h0;
    logic [31:0] flags_register_i = 32'h246, instruction_pointer_i = 32'h234, code_base_i = 32'h1000;
    logic [255:0] gpr_i = 256'h0;
    logic branch_evt_i = 1'b0, branch_pred_i = 1'b0, count_evt_i = 1'b0, slow = 1'b0;
    logic system_management_mode_i = 1'b0, machine_check_i = 1'b0, soft_init_i = 1'b0, real_mode_i = 1'b0;
    logic wb_ack_o, mem_req_o, mem_we_o, mem_ack_i, branch_irq_o, sampling_irq_o;
    logic [31:0] mem_addr_o, mem_wdata_o, mem_rdata_i;
    int bad_count = 0, compares = 0, cycles = 0, n_birq = 0, n_sirq = 0;
    trsw_writer i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .branch_evt_i, .branch_from_i, .branch_to_i, .branch_pred_i, .count_evt_i,
        .flags_register_i, .instruction_pointer_i, .code_base_i, .gpr_i, .system_management_mode_i,
        .machine_check_i, .soft_init_i, .real_mode_i, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o,
        .mem_ack_i, .mem_rdata_i, .branch_irq_o, .sampling_irq_o);
    trsw_mem_model u_mem (.clk_i, .rst_i, .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
        .wdata_i(mem_wdata_o), .slow_i(slow), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        n_birq += (branch_irq_o === 1'b1);
        n_sirq += (sampling_irq_o === 1'b1);
        if (cycles == 20000) begin
            bad_count++;
            wrap_up;
        end
    end
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask
    // classic cycle: hold everything until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q & mask, exp);
    endtask
    task automatic wait_word(input int idx, input logic [31:0] v);
        for (int i = 0; i < 300 && u_mem.m[idx] !== v; i++)
            @(posedge clk_i);
        chk(u_mem.m[idx], v);
    endtask
    task automatic br(input logic [31:0] f, input logic [31:0] t, input logic p);
        @(posedge clk_i);
        branch_evt_i <= 1'b1;
        branch_from_i <= f;
        branch_to_i <= t;
        branch_pred_i <= p;
        @(posedge clk_i);
        branch_evt_i <= 1'b0;
    endtask
    task automatic t_regs;
        rd(`TRSW_REG_CTRL, 32'hFFFFFFFF, 32'h0);
        rd(`TRSW_REG_MISC, 32'h1800, 32'h0);
        wr(`TRSW_REG_FEAT, 32'h0);
        rd(`TRSW_REG_FEAT, 32'h200000, 32'h200000);
        wr(8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'hFFFFFFFF, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_branch;
        logic [31:0] q;
        u_mem.m[0] = 32'h100;
        u_mem.m[1] = 32'h100;
        u_mem.m[2] = 32'h119;
        u_mem.m[3] = 32'h10C;
        real_mode_i <= 1'b1;
        wr(`TRSW_REG_AREA, 32'h0);
        wr(`TRSW_REG_CTRL, 32'h1);
        br(32'h4000, 32'h5000, 1'b1);
        wait_word(1, 32'h10C);
        chk(u_mem.m[8'h40], 32'h4000);
        chk(u_mem.m[8'h41], 32'h5000);
        chk(u_mem.m[8'h42], 32'h10);
        chk(n_birq, 0);
        br(32'h4100, 32'h6000, 1'b0);
        wait_word(1, 32'h118);
        chk(u_mem.m[8'h45], 32'h0);
        rd(`TRSW_REG_STAT, 32'h2, 32'h0);
        chk(n_birq, 1);
        // third record would pass the buffer end
        br(32'h4200, 32'h7000, 1'b1);
        for (int i = 0; i < 50 && q[1] !== 1'b1; i++)
            wb(1'b0, `TRSW_REG_STAT, 32'h0, q);
        chk(q & 32'h2, 32'h2);
        chk(u_mem.m[8'h46], 32'h0);
        chk(u_mem.m[1], 32'h118);
        wr(`TRSW_REG_STAT, 32'h1E);
        rd(`TRSW_REG_STAT, 32'h2, 32'h0);
        real_mode_i <= 1'b0;
        $display("test branch done");
    endtask
    task automatic t_sample;
        u_mem.m[4] = 32'h200;
        u_mem.m[5] = 32'h200;
        u_mem.m[6] = 32'h251;
        u_mem.m[7] = 32'h200;
        u_mem.m[8] = 32'h12345678;
        u_mem.m[9] = 32'hAB;
        slow <= 1'b1;
        wr(`TRSW_REG_CLO, 32'hFFFFFFFF);
        wr(`TRSW_REG_CHI, 32'hFF);
        wr(`TRSW_REG_CTRL, 32'h2);
        @(posedge clk_i);
        count_evt_i <= 1'b1;
        @(posedge clk_i);
        count_evt_i <= 1'b0;
        wait_word(5, 32'h228);
        chk(u_mem.m[8'h80], 32'h246);
        chk(u_mem.m[8'h81], 32'h1234);
        for (int i = 0; i < 8; i++)
            chk(u_mem.m[8'h82 + i], 32'hA0000000 + i);
        rd(`TRSW_REG_CLO, 32'hFFFFFFFF, 32'h12345678);
        rd(`TRSW_REG_CHI, 32'hFF, 32'hAB);
        chk(n_sirq, 1);
        slow <= 1'b0;
        $display("test sample done");
    endtask
    task automatic t_block;
        u_mem.m[1] = 32'h100;
        wr(`TRSW_REG_CTRL, 32'h1);
        system_management_mode_i <= 1'b1;
        rd(`TRSW_REG_CTRL, 32'h3, 32'h0);
        br(32'h4300, 32'h8000, 1'b1);
        rd(`TRSW_REG_STAT, 32'h1, 32'h0);
        chk(u_mem.m[1], 32'h100);
        system_management_mode_i <= 1'b0;
        wr(`TRSW_REG_CTRL, 32'h1);
        @(posedge clk_i);
        machine_check_i <= 1'b1;
        @(posedge clk_i);
        machine_check_i <= 1'b0;
        rd(`TRSW_REG_CTRL, 32'h3, 32'h0);
        wr(`TRSW_REG_CTRL, 32'h1);
        @(posedge clk_i);
        soft_init_i <= 1'b1;
        @(posedge clk_i);
        soft_init_i <= 1'b0;
        rd(`TRSW_REG_CTRL, 32'h3, 32'h0);
        // second branch arrives while the first is still pending: it is dropped
        wr(`TRSW_REG_CTRL, 32'h1);
        br(32'h4400, 32'h9000, 1'b0);
        br(32'h4500, 32'hA000, 1'b0);
        wait_word(1, 32'h10C);
        chk(u_mem.m[8'h40], 32'h4400);
        rd(`TRSW_REG_STAT, 32'h8, 32'h8);
        $display("test block done");
    endtask
    initial begin
        for (int i = 0; i < 256; i++)
            u_mem.m[i] = 32'h0;
        for (int i = 0; i < 8; i++)
            gpr_i[32 * i +: 32] = 32'hA0000000 + i;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_branch;
        t_sample;
        t_block;
        wrap_up;
    end
endmodule
